// >>> rtl/asc_sequence_control.sv
// converter sequencing control: registers, sample and conversion control, mux select
`timescale 1ns/10ps
// Notes on behaviour
// - simultaneous bit samples selected channels together
// - twelve-bit mode hides multi-channel fields as zero
// - autostart resamples after conversion, sets sample bit
// - trigger ends sampling; software clear if source zero
// - done set at finish, cleared at start
// - software may clear done; conversion undisturbed
// - reference field selects supply or external references
// - scan enable steps channel zero positive input
// - channel count selects one, two or four
// - buffer status shows half being filled
// - rate field N gives pulse per N+1
// - split mode alternates buffer halves per pulse
// - alternate mode toggles sample A and B
// - rc select chooses clock, ignores divider
// - auto sample time in clock periods, counter source
// - conversion period is divider plus one cycles, capped at 64
// - buffer length field gives two-power words
// - negative field picks vref, 6-8 or 9-11
// - positive bit picks inputs 3-5 or 0-2
// - trigger codes map to counter, pin, timers
// - resolution bit picks twelve or ten bit
module asc_sequence_control
   import asc_pkg::*;
#(
   parameter int CONV_PERIODS = 12
) (
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire logic [ASC_AW-1:0] addr_i,
   input  wire logic [ASC_DW-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [ASC_DW-1:0] rdata_o,
   input  wire logic              ext_pin_i,
   input  wire logic              timer_a_i,
   input  wire logic              timer_b_i,
   input  wire logic              rc_tick_i,
   output logic                   sampling_o,
   output logic                   converting_o,
   output logic                   sample_b_o,
   output asc_mux_s               mux_o,
   output logic                   scan_step_o,
   output logic                   event_o,
   output logic      [7:0]        buf_words_o
);
   logic              module_on, res12, simsel, autostart, sample_active, done;
   logic [2:0]        trig_src;
   logic [2:0]        ref_cfg;
   logic              scan_en, split_mode, alt_mode, buf_half;
   logic [1:0]        chan_cnt;
   logic [3:0]        rate;
   logic              rc_sel;
   logic [4:0]        sample_active_time;
   logic [7:0]        div;
   logic [2:0]        dma_len;
   logic [1:0]        neg_a, neg_b;
   logic              pos_a, pos_b;
   logic              use_b;
   asc_state_e        state;
   logic [7:0]        div_cnt;
   logic              tick;
   logic [4:0]        sample_active_cnt;
   logic [7:0]        conv_cnt;
   logic [3:0]        op_cnt;
   logic [2:0]        pin_sync;
   logic              pin_level;
   logic              pin_edge;
   logic              trig_hit;
   logic              conv_end;
   logic              conv_start;
   logic              wr1;

   ////////////////////////////////////////////////////////////////////////
   assign wr1 = wr_i && addr_i == ASC_ADDR_CON1;

   // pin trigger: three stages, a rising change counts when stages two and three agree
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         pin_sync  <= 3'h0;
         pin_level <= 1'b0;
      end else begin
         pin_sync <= {pin_sync[1:0], ext_pin_i};
         if (pin_sync[1] == pin_sync[2]) begin
            pin_level <= pin_sync[2];
         end
      end
   end
   assign pin_edge = (pin_sync[1] == pin_sync[2]) && pin_sync[2] && !pin_level;

   // conversion clock tick
   always_ff @(posedge clock_i) begin
      if (!rstn_i || rc_sel) begin
         div_cnt <= 8'h00;
      end else if (div_cnt >= div || div_cnt >= DIV_MAX) begin
         div_cnt <= 8'h00;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   // divider ignored under rc source
   assign tick = rc_sel ? rc_tick_i : (div_cnt >= div || div_cnt >= DIV_MAX);

   always_comb begin
      trig_hit = 1'b0;
      case (trig_src)
         TRG_PIN:  trig_hit = pin_edge;
         TRG_TMRA: trig_hit = timer_a_i;
         TRG_TMRB: trig_hit = timer_b_i;
         // the tick that completes the last period ends sampling, not the one after
         TRG_AUTO: trig_hit = sample_active_time == 5'h00 ||
                              (tick && 6'(sample_active_cnt) + 6'h01 >= 6'(sample_active_time));
         default:  trig_hit = 1'b0;
      endcase
   end

   assign conv_start = state == ASC_SAMPLE &&
                       (trig_src == TRG_SOFT ? !sample_active : trig_hit);
   assign conv_end   = state == ASC_CONVERT && tick &&
                       conv_cnt == 8'(CONV_PERIODS - 1);

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state    <= ASC_IDLE;
         sample_active_cnt <= 5'h00;
         conv_cnt <= 8'h00;
      end else if (!module_on) begin
         state <= ASC_IDLE;
      end else begin
         case (state)
            ASC_IDLE: begin
               sample_active_cnt <= 5'h00;
               if (sample_active) begin
                  state <= ASC_SAMPLE;
               end
            end
            ASC_SAMPLE: begin
               if (conv_start) begin
                  state    <= ASC_CONVERT;
                  conv_cnt <= 8'h00;
               end else if (tick && sample_active_cnt != 5'h1F) begin
                  sample_active_cnt <= sample_active_cnt + 5'h01;
               end
            end
            ASC_CONVERT: begin
               if (tick) begin
                  conv_cnt <= conv_cnt + 8'h01;
               end
               if (conv_end) begin
                  sample_active_cnt <= 5'h00;
                  state    <= autostart ? ASC_SAMPLE : ASC_IDLE;
               end
            end
            default: state <= ASC_IDLE;
         endcase
      end
   end

   // sample bit: hardware set at conversion end under autostart wins over software
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sample_active <= 1'b0;
      end else if (conv_end && autostart) begin
         sample_active <= 1'b1;
      end else if (conv_start && trig_src != TRG_SOFT) begin
         sample_active <= 1'b0;
      end else if (wr1) begin
         sample_active <= wdata_i[C1_SAMPLE_ACTIVE];
      end else if (module_on && autostart && state == ASC_IDLE) begin
         sample_active <= 1'b1;
      end
   end

   // done flag: set wins over a software clear; writing one is ignored
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         done <= 1'b0;
      end else if (conv_end) begin
         done <= 1'b1;
      end else if (conv_start) begin
         done <= 1'b0;
      end else if (wr1 && !wdata_i[C1_DONE]) begin
         done <= 1'b0;
      end
   end

   // operation counter, buffer half and alternate sample
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         op_cnt   <= 4'h0;
         event_o  <= 1'b0;
         buf_half <= 1'b0;
         use_b    <= 1'b0;
      end else begin
         event_o <= 1'b0;
         if (conv_end) begin
            use_b <= alt_mode ? !use_b : 1'b0;
            if (op_cnt >= rate) begin
               op_cnt  <= 4'h0;
               event_o <= 1'b1;
               buf_half <= split_mode ? !buf_half : 1'b0;
            end else begin
               op_cnt <= op_cnt + 4'h1;
            end
         end
         if (!alt_mode) begin
            use_b <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         module_on <= 1'b0;
         res12     <= 1'b0;
         trig_src  <= 3'h0;
         simsel    <= 1'b0;
         autostart <= 1'b0;
         ref_cfg   <= 3'h0;
         scan_en   <= 1'b0;
         chan_cnt  <= 2'h0;
         rate      <= 4'h0;
         split_mode <= 1'b0;
         alt_mode  <= 1'b0;
         rc_sel    <= 1'b0;
         sample_active_time <= 5'h00;
         div       <= 8'h00;
         dma_len   <= 3'h0;
         neg_a     <= 2'h0;
         neg_b     <= 2'h0;
         pos_a     <= 1'b0;
         pos_b     <= 1'b0;
      end else if (wr_i) begin
         case (addr_i)
            ASC_ADDR_CON1: begin
               module_on <= wdata_i[C1_ON];
               res12     <= wdata_i[C1_RES];
               trig_src  <= wdata_i[C1_TRG +: 3];
               simsel    <= wdata_i[C1_SIM];
               autostart <= wdata_i[C1_AUTO];
            end
            ASC_ADDR_CON2: begin
               ref_cfg    <= wdata_i[C2_REF +: 3];
               scan_en    <= wdata_i[C2_SCAN];
               chan_cnt   <= wdata_i[C2_CHN +: 2];
               rate       <= wdata_i[C2_RATE +: 4];
               split_mode <= wdata_i[C2_SPLIT];
               alt_mode   <= wdata_i[C2_ALT];
            end
            ASC_ADDR_CON3: begin
               rc_sel    <= wdata_i[C3_RC];
               sample_active_time <= wdata_i[C3_SAMT +: 5];
               div       <= wdata_i[C3_DIV +: 8];
            end
            ASC_ADDR_CON4: dma_len <= wdata_i[2:0];
            ASC_ADDR_CHS: begin
               neg_b <= wdata_i[CS_NB +: 2];
               pos_b <= wdata_i[CS_PB];
               neg_a <= wdata_i[CS_NA +: 2];
               pos_a <= wdata_i[CS_PA];
            end
            default: ;
         endcase
      end
   end

   // register reads; fields absent in twelve-bit mode read zero
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         rdata_o <= 16'h0000;
         case (addr_i)
            ASC_ADDR_CON1: begin
               rdata_o[C1_ON]       <= module_on;
               rdata_o[C1_RES]      <= res12;
               rdata_o[C1_TRG +: 3] <= trig_src;
               rdata_o[C1_SIM]      <= simsel && !res12;
               rdata_o[C1_AUTO]     <= autostart;
               rdata_o[C1_SAMPLE_ACTIVE]     <= sample_active;
               rdata_o[C1_DONE]     <= done;
            end
            ASC_ADDR_CON2: begin
               rdata_o[C2_REF +: 3]  <= ref_cfg;
               rdata_o[C2_SCAN]      <= scan_en;
               rdata_o[C2_CHN +: 2]  <= res12 ? 2'h0 : chan_cnt;
               rdata_o[C2_BUFFER_HALF_STATUS]      <= buf_half;
               rdata_o[C2_RATE +: 4] <= rate;
               rdata_o[C2_SPLIT]     <= split_mode;
               rdata_o[C2_ALT]       <= alt_mode;
            end
            ASC_ADDR_CON3: begin
               rdata_o[C3_RC]       <= rc_sel;
               rdata_o[C3_SAMT +: 5] <= sample_active_time;
               rdata_o[C3_DIV +: 8] <= div;
            end
            ASC_ADDR_CON4: rdata_o[2:0] <= dma_len;
            ASC_ADDR_CHS: if (!res12) begin
               rdata_o[CS_NB +: 2] <= neg_b;
               rdata_o[CS_PB]      <= pos_b;
               rdata_o[CS_NA +: 2] <= neg_a;
               rdata_o[CS_PA]      <= pos_a;
            end
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mux outputs towards the analog core, registered
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         mux_o       <= '0;
         buf_words_o <= 8'h01;
         scan_step_o <= 1'b0;
      end else begin
         mux_o.pos_high <= use_b ? pos_b : pos_a;
         mux_o.neg_sel  <= (use_b ? neg_b : neg_a) & {1'b1, 1'b1};
         if ((use_b ? neg_b[1] : neg_a[1]) == 1'b0) begin
            mux_o.neg_sel <= NEG_VREF;
         end
         mux_o.ref_sel <= ref_cfg[2] ? REF_INT : ref_cfg[1:0];
         mux_o.chan_mask <= res12 ? 3'h0 :
                            chan_cnt[1] ? 3'h7 : (chan_cnt[0] ? 3'h1 : 3'h0);
         mux_o.simultaneous <= simsel && !res12 && chan_cnt != 2'h0;
         mux_o.scan <= scan_en && !use_b;
         scan_step_o <= scan_en && !use_b && conv_end;
         buf_words_o <= 8'h01 << dma_len;
      end
   end

   assign sampling_o   = state == ASC_SAMPLE;
   assign converting_o = state == ASC_CONVERT;
   assign sample_b_o   = use_b;

   ////////////////////////////////////////////////////////////////////////
   done_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      conv_start |=> !done) else $error("done not cleared at start");
   done_set_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      conv_end |=> done) else $error("done not set at end");
   soft_start_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (state == ASC_SAMPLE && trig_src == TRG_SOFT && !sample_active && module_on)
      |=> state == ASC_CONVERT) else $error("soft clear did not start");
   hw_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (conv_start && trig_src != TRG_SOFT && !(conv_end && autostart))
      |=> !sample_active) else $error("sample bit not cleared");
   auto_set_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (conv_end && autostart) |=> sample_active && state == ASC_SAMPLE)
      else $error("autostart did not resample");
   rate_event_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (conv_end && op_cnt >= rate) |=> event_o && op_cnt == 4'h0)
      else $error("rate pulse missing");
   res_hide_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (rd_i && addr_i == ASC_ADDR_CHS && res12) |=> rdata_o == 16'h0000)
      else $error("channel select visible in twelve-bit");
   ref_map_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      $past(ref_cfg[2]) |-> mux_o.ref_sel == REF_INT)
      else $error("reference map wrong");
   alt_mode_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !alt_mode |=> !use_b) else $error("sample b used without alternate");
endmodule

// >>> rtl/asc_pkg.sv
// package: register map, field positions and constants of the converter sequencer
package asc_pkg;
   localparam logic [2:0] ASC_ADDR_CON1  = 3'h0;
   localparam logic [2:0] ASC_ADDR_CON2  = 3'h1;
   localparam logic [2:0] ASC_ADDR_CON3  = 3'h2;
   localparam logic [2:0] ASC_ADDR_CON4  = 3'h3;
   localparam logic [2:0] ASC_ADDR_CHS   = 3'h4;
   localparam int ASC_AW = 3;
   localparam int ASC_DW = 16;
   // control one bit positions
   localparam int C1_ON    = 15;
   localparam int C1_RES   = 10;
   localparam int C1_TRG   = 5;
   localparam int C1_SIM   = 3;
   localparam int C1_AUTO  = 2;
   localparam int C1_SAMPLE_ACTIVE  = 1;
   localparam int C1_DONE  = 0;
   // control two bit positions
   localparam int C2_REF   = 13;
   localparam int C2_SCAN  = 10;
   localparam int C2_CHN   = 8;
   localparam int C2_BUFFER_HALF_STATUS  = 7;
   localparam int C2_RATE  = 2;
   localparam int C2_SPLIT = 1;
   localparam int C2_ALT   = 0;
   // control three bit positions
   localparam int C3_RC    = 15;
   localparam int C3_SAMT  = 8;
   localparam int C3_DIV   = 0;
   // channel select bit positions
   localparam int CS_NB    = 9;
   localparam int CS_PB    = 8;
   localparam int CS_NA    = 1;
   localparam int CS_PA    = 0;
   localparam logic [2:0] TRG_SOFT  = 3'h0;
   localparam logic [2:0] TRG_PIN   = 3'h1;
   localparam logic [2:0] TRG_TMRA  = 3'h2;
   localparam logic [2:0] TRG_TMRB  = 3'h4;
   localparam logic [2:0] TRG_AUTO  = 3'h7;
   localparam logic [7:0] DIV_MAX   = 8'h3F;
   localparam logic [1:0] REF_INT   = 2'h0;
   localparam logic [1:0] REF_POS   = 2'h1;
   localparam logic [1:0] REF_NEG   = 2'h2;
   localparam logic [1:0] REF_BOTH  = 2'h3;
   localparam logic [1:0] NEG_VREF  = 2'h0;
   localparam logic [1:0] NEG_LOW   = 2'h2;
   localparam logic [1:0] NEG_HIGH  = 2'h3;

   typedef enum logic [1:0] {ASC_IDLE, ASC_SAMPLE, ASC_CONVERT} asc_state_e;

   typedef struct packed {
      logic       pos_high;   // inputs 3..5 instead of 0..2
      logic [1:0] neg_sel;    // vref-, 6..8 or 9..11
      logic [1:0] ref_sel;    // reference pair
      logic [2:0] chan_mask;  // channels 1..3 in use
      logic       simultaneous;
      logic       scan;
   } asc_mux_s;
endpackage

// >>> bench/asc_dma_model.sv
// dma side model: counts transfer requests raised by the sequencer
`timescale 1ns/10ps
module asc_dma_model (
   input  wire logic       clock_i,
   input  wire logic       rstn_i,
   input  wire logic       event_i,
   output logic      [7:0] req_count_o
);
   // one pointer step per clock cycle that the request is high, no edge detection
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         req_count_o <= 8'h00;
      end else if (event_i) begin
         req_count_o <= req_count_o + 8'h01;
      end
   end
endmodule

// >>> bench/asc_sequence_control_tb_top.sv
// self-checking bench of the converter sequencer
`timescale 1ns/10ps
module asc_sequence_control_tb_top
   import asc_pkg::*;
;
   localparam int CP = 2;
   logic              clock_i;
   logic              rstn_i;
   logic [ASC_AW-1:0] addr;
   logic [ASC_DW-1:0] wdata;
   logic [ASC_DW-1:0] rdata;
   logic              wr, rd, ext_pin, timer_a, timer_b, rc_tick, rc_run;
   logic              sampling, converting, sample_b, scan_step, event_p;
   asc_mux_s          mux;
   logic [7:0]        buf_words, req_count;
   logic [31:0]       seed;
   logic [15:0]       q, v, c1, c2, cs;
   logic [2:0]        a;
   logic [2:0]        trg [3];
   int                mismatches, total_checks, cycles, n, scan_cnt;

   asc_sequence_control #(.CONV_PERIODS(CP)) u_dut (
      .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_pin_i(ext_pin),
      .timer_a_i(timer_a), .timer_b_i(timer_b), .rc_tick_i(rc_tick),
      .sampling_o(sampling), .converting_o(converting), .sample_b_o(sample_b),
      .mux_o(mux), .scan_step_o(scan_step), .event_o(event_p), .buf_words_o(buf_words)
   );
   asc_dma_model u_dma (
      .clock_i(clock_i), .rstn_i(rstn_i), .event_i(event_p), .req_count_o(req_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // rc ticks only when enabled, to prove the divider is not used instead
   always @(posedge clock_i) begin
      cycles   <= cycles + 1;
      rc_tick  <= rc_run & (cycles[1:0] == 2'b00);
      if (scan_step === 1'b1) scan_cnt <= scan_cnt + 1;
      if (cycles == 30000) begin
         mismatches++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [15:0] wmask(logic [2:0] r);
      case (r)
         ASC_ADDR_CON2: return 16'hE73F;
         ASC_ADDR_CON3: return 16'h9FFF;
         ASC_ADDR_CON4: return 16'h0007;
         ASC_ADDR_CHS:  return 16'h0707;
         default:       return 16'h0000;
      endcase
   endfunction

   // sample A selections, ten-bit mode
   function automatic asc_mux_s exp_mux(logic [15:0] r1, logic [15:0] r2, logic [15:0] rs);
      asc_mux_s m;
      m.pos_high     = rs[CS_PA];
      m.neg_sel      = rs[CS_NA+1] ? rs[CS_NA+:2] : NEG_VREF;
      m.ref_sel      = r2[15] ? REF_INT : r2[14:13];
      m.chan_mask    = r2[9] ? 3'h7 : {2'h0, r2[8]};
      m.simultaneous = r1[C1_SIM];
      m.scan         = r2[C2_SCAN];
      return m;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [ASC_AW-1:0] ad, input logic [ASC_DW-1:0] d);
      @(posedge clock_i);
      addr  <= ad;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_i);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [ASC_AW-1:0] ad, output logic [ASC_DW-1:0] d);
      @(posedge clock_i);
      addr <= ad;
      rd   <= 1'b1;
      @(posedge clock_i);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic wait_sig(input logic conv, input logic lvl, input int lim);
      #1;
      n = 0;
      while (((conv ? converting : sampling) !== lvl) && n < lim) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      total_checks++;
      if (n >= lim) begin
         mismatches++;
         $display("wrong value at %0t: wait on flag %0d timed out", $time, conv);
      end
   endtask

   task automatic pulse(input logic [2:0] code);
      @(posedge clock_i);
      ext_pin <= (code == TRG_PIN);
      timer_a <= (code == TRG_TMRA);
      timer_b <= (code == TRG_TMRB);
      @(posedge clock_i);
      {timer_a, timer_b} <= 2'h0;
      // pin filter needs two agreeing samples, so the pin stays up longer
      repeat (2) @(posedge clock_i);
      ext_pin <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {addr, wdata, wr, rd, ext_pin, timer_a, timer_b, rc_tick, rc_run} = '0;
      {mismatches, total_checks, cycles, scan_cnt} = '0;
      seed   = 32'h730C54FD;
      trg    = '{TRG_PIN, TRG_TMRA, TRG_TMRB};
      rstn_i = 1'b0;
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd_reg(3'(i), q);
         chk(q, 16'h0000);
      end
      chk(16'(buf_words), 16'h0001);
      // random readback, unmapped index included
      for (int i = 0; i < 16; i++) begin
         a = 3'h1 + 3'(rnd() & 3);
         v = 16'(rnd());
         wr_reg(a, v);
         rd_reg(a, q);
         chk(q, v & wmask(a));
         if (a == ASC_ADDR_CON4) chk(16'(buf_words), 16'(1 << v[2:0]));
      end
      wr_reg(3'h5, 16'(rnd()));
      rd_reg(3'h5, q);
      chk(q, 16'h0000);
      // every reference code, random channel and input selections
      for (int i = 0; i < 8; i++) begin
         c2 = (16'(rnd()) & 16'h0700) | 16'(i << C2_REF);
         cs = 16'(rnd()) & 16'h0707;
         c1 = 16'h8000 | (16'(rnd() & (c2[9] | c2[8])) << C1_SIM);
         wr_reg(ASC_ADDR_CON1, c1);
         wr_reg(ASC_ADDR_CON2, c2);
         wr_reg(ASC_ADDR_CHS, cs);
         repeat (2) @(posedge clock_i);
         chk(16'(mux), 16'(exp_mux(c1, c2, cs)));
      end
      // twelve-bit mode hides the multi-channel fields
      wr_reg(ASC_ADDR_CON1, 16'h0408);
      wr_reg(ASC_ADDR_CON2, 16'h0300);
      wr_reg(ASC_ADDR_CHS, 16'h0707);
      rd_reg(ASC_ADDR_CON1, q);
      chk(q, 16'h0400);
      rd_reg(ASC_ADDR_CON2, q);
      chk(q, 16'h0000);
      rd_reg(ASC_ADDR_CHS, q);
      chk(q, 16'h0000);
      chk(16'(mux.chan_mask), 16'h0000);
      // soft trigger, rate 2, split and alternate modes
      wr_reg(ASC_ADDR_CON1, 16'h0000);
      wr_reg(ASC_ADDR_CON3, 16'h0003);
      wr_reg(ASC_ADDR_CON2, 16'h000B);
      for (int k = 0; k < 6; k++) begin
         wr_reg(ASC_ADDR_CON1, 16'h8002);
         wait_sig(1'b0, 1'b1, 10);
         chk(16'(sample_b), 16'(k & 1));
         wr_reg(ASC_ADDR_CON1, 16'h8000);
         wait_sig(1'b1, 1'b1, 10);
         wr_reg(ASC_ADDR_CON1, 16'h8000);
         chk(16'(converting), 16'h0001);
         rd_reg(ASC_ADDR_CON1, q);
         chk(q, 16'h8000);
         wait_sig(1'b1, 1'b0, 40);
         rd_reg(ASC_ADDR_CON1, q);
         chk(q, 16'h8001);
         chk(16'(req_count), 16'((k + 1) / 3));
         rd_reg(ASC_ADDR_CON2, q);
         chk(16'(q[C2_BUFFER_HALF_STATUS]), 16'(((k + 1) / 3) & 1));
         if (k == 0) begin
            wr_reg(ASC_ADDR_CON1, 16'h8000);
            wr_reg(ASC_ADDR_CON1, 16'h8001);
            rd_reg(ASC_ADDR_CON1, q);
            chk(q, 16'h8000);
         end
      end
      chk(16'(scan_cnt), 16'h0000);
      // hardware trigger sources with scanning on
      wr_reg(ASC_ADDR_CON2, 16'h0400);
      for (int i = 0; i < 3; i++) begin
         wr_reg(ASC_ADDR_CON1, 16'h8002 | (16'(trg[i]) << C1_TRG));
         wait_sig(1'b0, 1'b1, 10);
         repeat (6) @(posedge clock_i);
         chk(16'(sampling), 16'h0001);
         pulse(trg[i]);
         wait_sig(1'b1, 1'b1, 10);
         rd_reg(ASC_ADDR_CON1, q);
         chk(16'(q[C1_SAMPLE_ACTIVE]), 16'h0000);
         wait_sig(1'b1, 1'b0, 40);
      end
      repeat (2) @(posedge clock_i);
      chk(16'(scan_cnt), 16'h0003);
      chk(16'(req_count), 16'h0005);
      // internal counter with autostart on the rc clock
      wr_reg(ASC_ADDR_CON3, 16'h8300);
      wr_reg(ASC_ADDR_CON1, 16'h80E4);
      wait_sig(1'b0, 1'b1, 10);
      repeat (30) @(posedge clock_i);
      chk(16'(sampling), 16'h0001);
      rc_run <= 1'b1;
      wait_sig(1'b1, 1'b1, 60);
      wait_sig(1'b1, 1'b0, 40);
      wait_sig(1'b0, 1'b1, 5);
      wait_sig(1'b0, 1'b0, 60);
      // three sample periods of four clock cycles each
      chk(16'(n), 16'(3 * 4));
      rd_reg(ASC_ADDR_CON1, q);
      chk(16'(q[C1_SAMPLE_ACTIVE] | converting), 16'h0001);
      wr_reg(ASC_ADDR_CON1, 16'h0000);
      wait_sig(1'b0, 1'b0, 5);
      end_sim();
   end
endmodule
